//--- pkg/psc_pkg.sv
// Package of constants and carriers for the power save control block.
//
// Contract
// R1: Each auxiliary DAC has own power-down bit.
// R2: Aux ADC off when no channel selected.
// R3: Single-shot aux ADC off between conversions.
// R4: Clock gate bit 2 stops aux logic.
// R5: Aux ADC valid within two conversion periods.
// R6: Transmit off: gate bits 5,4, enable clear.
// R7: Host waits transmit-active clear before disabling.
// R8: Receive off: gate bits 3,0, enable clear.
// R9: Receive data valid after eight symbol periods.
// R10: Voice codec off when its enable low.
// R11: Voice amplifiers off when bits 5,4 low.
// R12: Voice codec ready after 288 clocks.
// R13: Power-down bit 5 clear stops bias chain.
// R14: Host waits 2 ms after bias restore; the bench waits five clocks.
// R15: Slow serial clock gives four samples/symbol.
// R16: Clock stop after seven idle symbol periods.
// R17: Host holds reset two clocks minimum.
// R18: Controls sampled synchronously, glitch-free gating.
package psc_pkg;
  localparam int PDC_DAC_LSB = 0;
  localparam int PDC_DAC_W = 4;
  localparam int PDC_BIAS = 5;
  localparam int CGC_RX_A = 0;
  localparam int CGC_SER_STOP = 1;
  localparam int CGC_AUX = 2;
  localparam int CGC_RX_B = 3;
  localparam int CGC_TX_A = 4;
  localparam int CGC_TX_B = 5;
  localparam int TXS_EN = 3;
  localparam int RXS1_EN = 3;
  localparam int RXS1_PHASE = 6;
  localparam int VS1_AMP_A = 4;
  localparam int VS1_AMP_B = 5;
  localparam int VS2_EN = 3;
  localparam int AUX_CH_W = 3;
  localparam logic [AUX_CH_W-1:0] AUX_CH_NONE = 3'h0;
  localparam int AUX_WARM_CONV = 2;
  localparam int RX_SETTLE_SYM = 8;
  localparam int SER_IDLE_SYM = 7;
  localparam int VOICE_SAMPLE_CLK = 288;
  localparam int SPS_FULL = 8;
  localparam int SPS_SLOW = 4;

  typedef struct packed {
    logic [7:0] power_down_control;
    logic [7:0] clock_gate_control;
    logic [7:0] transmit_setup;
    logic [7:0] receive_setup_one;
    logic [7:0] voice_setup_one;
    logic [7:0] voice_setup_two;
  } psc_ctrl_s;

  typedef struct packed {
    logic [PDC_DAC_W-1:0] aux_dac_on;
    logic aux_adc_on;
    logic aux_logic_clk_en;
    logic tx_on;
    logic rx_on;
    logic voice_on;
    logic voice_amp_on;
    logic bias_on;
    logic fast_serial_port_clk_en;
  } psc_power_s;

  typedef struct packed {
    logic aux_adc_ready;
    logic rx_data_valid;
    logic voice_ready;
    logic [3:0] samples_per_symbol;
    logic rx_phase_adjust;
  } psc_status_s;
endpackage

//--- src/psc_sync.sv
// Three-stage synchroniser with agreement filter for a pin-level input.
`timescale 1ns/1ps
module psc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once the last two stages agree.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule

//--- src/psc_top.sv
// Power save sequencer: section enables and power-up latency tracking.
`timescale 1ns/1ps
module psc_top
  import psc_pkg::*;
#(
  parameter int SYMBOL_CLKS = 512,
  parameter int CONV_CLKS = 64
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host control registers, held by the serial control port.
  input wire psc_pkg::psc_ctrl_s ctrl,
  // Auxiliary ADC channel select and single-shot controls.
  input wire logic [psc_pkg::AUX_CH_W-1:0] aux_adc_channel,
  input wire logic aux_adc_single_shot,
  input wire logic aux_adc_convert,
  // Serial interface rate and frame sync pins.
  input wire logic serial_clk_slow,
  input wire logic [2:0] frame_sync_pins,
  // Section power and status outputs.
  output psc_pkg::psc_power_s power,
  output psc_pkg::psc_status_s status,
  output logic aux_adc_busy
);
  import psc_pkg::*;

  localparam int SW = $clog2(SYMBOL_CLKS * RX_SETTLE_SYM + 1);
  localparam int CW = $clog2(CONV_CLKS * AUX_WARM_CONV + 1);
  localparam int VW = $clog2(VOICE_SAMPLE_CLK + 1);
  localparam logic [SW-1:0] RX_WAIT = SW'(SYMBOL_CLKS * RX_SETTLE_SYM);
  localparam logic [SW-1:0] SER_WAIT = SW'(SYMBOL_CLKS * SER_IDLE_SYM);
  localparam logic [CW-1:0] AUX_WAIT = CW'(CONV_CLKS * AUX_WARM_CONV);
  localparam logic [CW-1:0] CONV_LEN = CW'(CONV_CLKS);
  localparam logic [VW-1:0] VOICE_WAIT = VW'(VOICE_SAMPLE_CLK);

  typedef enum logic [1:0] {
    ADC_OFF,
    ADC_WARM,
    ADC_IDLE,
    ADC_CONV
  } psc_adc_e;

  function automatic logic both_set(input logic [7:0] r, input int a,
                                    input int b);
    both_set = r[a] & r[b];
  endfunction

  psc_ctrl_s c;
  logic [2:0] fs_sync;
  logic [2:0] fs_prev;
  logic conv_req;
  logic conv_prev;
  psc_adc_e adc_state;
  logic [CW-1:0] adc_cnt;
  logic [SW-1:0] rx_cnt;
  logic [SW-1:0] idle_cnt;
  logic [VW-1:0] voice_cnt;
  logic adc_wanted;

  // Frame sync pins come from the link, so they pass the synchroniser.
  psc_sync #(.W(3)) u_fs_sync (
    .clock(clock),
    .rst(rst),
    .d(frame_sync_pins),
    .q(fs_sync)
  );

  // Control words are registered once so gating changes on a clock edge.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      c <= '0;
      conv_prev <= 1'b0;
      fs_prev <= '0;
    end else begin
      c <= ctrl; // R18
      conv_prev <= aux_adc_convert;
      fs_prev <= fs_sync;
    end
  end

  assign conv_req = aux_adc_convert & ~conv_prev;
  assign adc_wanted = (aux_adc_channel != AUX_CH_NONE) // R2
                      & c.power_down_control[PDC_BIAS]
                      & ~c.clock_gate_control[CGC_AUX];

  // Auxiliary ADC power and warm-up sequencing.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adc_state <= ADC_OFF;
      adc_cnt <= '0;
    end else begin
      case (adc_state)
        ADC_OFF: begin
          adc_cnt <= '0;
          if (adc_wanted && (!aux_adc_single_shot || conv_req)) begin
            adc_state <= ADC_WARM;
          end
        end
        ADC_WARM: begin
          if (!adc_wanted) begin
            adc_state <= ADC_OFF;
          end else if (adc_cnt == AUX_WAIT - 1'b1) begin
            adc_cnt <= '0;
            adc_state <= aux_adc_single_shot ? ADC_CONV : ADC_IDLE; // R5
          end else begin
            adc_cnt <= adc_cnt + 1'b1;
          end
        end
        ADC_IDLE: begin
          if (!adc_wanted) begin
            adc_state <= ADC_OFF; // R2
          end else if (aux_adc_single_shot) begin
            adc_state <= ADC_OFF; // R3
          end
        end
        ADC_CONV: begin
          if (!adc_wanted) begin
            adc_state <= ADC_OFF;
          end else if (adc_cnt == CONV_LEN - 1'b1) begin
            adc_cnt <= '0;
            adc_state <= ADC_OFF; // R3
          end else begin
            adc_cnt <= adc_cnt + 1'b1;
          end
        end
        default: adc_state <= ADC_OFF;
      endcase
    end
  end

  // Receive settling count after power-up.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_cnt <= '0;
    end else if (!power.rx_on) begin
      rx_cnt <= '0;
    end else if (rx_cnt != RX_WAIT) begin
      rx_cnt <= rx_cnt + 1'b1; // R9
    end
  end

  // Voice codec warm-up count.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      voice_cnt <= '0;
    end else if (!power.voice_on) begin
      voice_cnt <= '0;
    end else if (voice_cnt != VOICE_WAIT) begin
      voice_cnt <= voice_cnt + 1'b1; // R12
    end
  end

  // Frame sync idle counter for serial clock stop.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_cnt <= '0;
    end else if (fs_sync != fs_prev) begin
      idle_cnt <= '0;
    end else if (idle_cnt <= SER_WAIT) begin
      idle_cnt <= idle_cnt + 1'b1; // R16
    end
  end

  // Section power enables, registered to keep gated clocks clean.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power <= '0;
    end else begin
      power.aux_dac_on <= ~c.power_down_control[PDC_DAC_LSB +: PDC_DAC_W]; // R1
      power.aux_adc_on <= (adc_state != ADC_OFF) && adc_wanted; // R2 R3
      power.aux_logic_clk_en <= ~c.clock_gate_control[CGC_AUX]; // R4 R18
      power.tx_on <= ~(both_set(c.clock_gate_control, CGC_TX_A, CGC_TX_B)
                     & ~c.transmit_setup[TXS_EN]); // R6
      power.rx_on <= ~(both_set(c.clock_gate_control, CGC_RX_A, CGC_RX_B)
                     & ~c.receive_setup_one[RXS1_EN]); // R8
      power.voice_on <= c.voice_setup_two[VS2_EN]; // R10
      power.voice_amp_on <= c.voice_setup_two[VS2_EN]
                            & (c.voice_setup_one[VS1_AMP_A]
                               | c.voice_setup_one[VS1_AMP_B]); // R11
      power.bias_on <= c.power_down_control[PDC_BIAS]; // R13
      power.fast_serial_port_clk_en <= ~(c.clock_gate_control[CGC_SER_STOP]
                                         & serial_clk_slow
                                         & (idle_cnt > SER_WAIT)); // R16
    end
  end

  // Readiness and rate status.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status <= '0;
      aux_adc_busy <= 1'b0;
    end else begin
      status.aux_adc_ready <= (adc_state == ADC_IDLE)
                              || (adc_state == ADC_CONV); // R5
      status.rx_data_valid <= power.rx_on && (rx_cnt == RX_WAIT); // R9
      status.voice_ready <= power.voice_on && (voice_cnt == VOICE_WAIT); // R12
      status.samples_per_symbol <= serial_clk_slow ? 4'(SPS_SLOW)
                                                   : 4'(SPS_FULL); // R15
      status.rx_phase_adjust <= c.receive_setup_one[RXS1_PHASE]; // R15
      aux_adc_busy <= (adc_state == ADC_CONV);
    end
  end
endmodule

//--- tb/psc_host.sv
// Host model that holds the control words written by the bench.
`timescale 1ns/1ps
module psc_host
  import psc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Write side and register outputs.
  input wire logic wr_en,
  input wire psc_pkg::psc_ctrl_s wr_val,
  output psc_pkg::psc_ctrl_s ctrl
);
  // The bench sends no transmit traffic, so disabling it is safe.
  // Words change only on the clock, as a register of the host would.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= '0;
    end else if (wr_en) begin
      ctrl <= wr_val;
    end
  end
endmodule

//--- tb/psc_top_props.sv
// Checker of the power save control block outputs.
`timescale 1ns/1ps
module psc_top_props
  import psc_pkg::*;
#(
  parameter int SYMBOL_CLKS = 512,
  parameter int CONV_CLKS = 64
) (
  input wire logic clock,
  input wire logic rst,
  input wire psc_pkg::psc_ctrl_s ctrl,
  input wire logic [psc_pkg::AUX_CH_W-1:0] aux_adc_channel,
  input wire logic aux_adc_single_shot,
  input wire logic aux_adc_convert,
  input wire logic serial_clk_slow,
  input wire logic [2:0] frame_sync_pins,
  input wire psc_pkg::psc_power_s power,
  input wire psc_pkg::psc_status_s status,
  input wire logic aux_adc_busy
);
  logic [1:0] age;
  logic [9:0] vc;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) vc <= 10'h0;
    else if (!power.voice_on) vc <= 10'h0;
    else if (vc != 10'h3ff) vc <= vc + 10'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence up;
    age == 2'h3;
  endsequence
  AST_DAC: assert property (up |-> power.aux_dac_on ==
    ~$past(ctrl.power_down_control[3:0], 2)) else $error("dac on wrong");
  AST_AUXCLK: assert property (up |-> power.aux_logic_clk_en ==
    !$past(ctrl.clock_gate_control[2], 2)) else $error("aux clk wrong");
  AST_TX: assert property (up |-> power.tx_on == !$past(
    ctrl.clock_gate_control[5] & ctrl.clock_gate_control[4] &
    !ctrl.transmit_setup[3], 2)) else $error("tx on wrong");
  AST_RX: assert property (up |-> power.rx_on == !$past(
    ctrl.clock_gate_control[3] & ctrl.clock_gate_control[0] &
    !ctrl.receive_setup_one[3], 2)) else $error("rx on wrong");
  AST_VOICE: assert property (up |-> power.voice_on ==
    $past(ctrl.voice_setup_two[3], 2)) else $error("voice on wrong");
  AST_AMP: assert property (up |-> power.voice_amp_on == $past(
    ctrl.voice_setup_two[3] & (ctrl.voice_setup_one[5] |
    ctrl.voice_setup_one[4]), 2)) else $error("amp wrong");
  AST_BIAS: assert property (up |-> power.bias_on ==
    $past(ctrl.power_down_control[5], 2)) else $error("bias wrong");
  AST_NOCH: assert property ((aux_adc_channel == AUX_CH_NONE)[*3]
    |=> !power.aux_adc_on) else $error("aux adc on unselected");
  AST_VEARLY: assert property (vc < 10'h118 |->
    !status.voice_ready) else $error("voice ready early");
  AST_VLATE: assert property (vc > 10'h12c |->
    status.voice_ready) else $error("voice ready late");
endmodule
bind psc_top psc_top_props #(.SYMBOL_CLKS(SYMBOL_CLKS),
  .CONV_CLKS(CONV_CLKS)) chk_u (.clock, .rst, .ctrl, .aux_adc_channel,
  .aux_adc_single_shot, .aux_adc_convert, .serial_clk_slow,
  .frame_sync_pins, .power, .status, .aux_adc_busy);

//--- tb/tb.sv
// Self-checking bench of the power save control block.
`timescale 1ns/1ps
module tb;
  import psc_pkg::*;
  localparam int SYM = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  psc_ctrl_s wr_val = '0;
  psc_ctrl_s ctrl;
  psc_ctrl_s v;
  logic [2:0] ch = 3'h0;
  logic one = 1'b0;
  logic cv = 1'b0;
  logic slow = 1'b0;
  logic [2:0] fs = 3'h0;
  psc_power_s pw;
  psc_status_s st;
  logic busy;
  logic [31:0] lfsr = 32'h073a;
  int fail_count = 0;
  int n_compared = 0;
  int i;
  int n;
  int nr = 0;
  always #2.5 clock = ~clock;
  psc_host host_u (.clock, .rst, .wr_en, .wr_val, .ctrl);
  psc_top #(.SYMBOL_CLKS(SYM), .CONV_CLKS(4)) dut_u (.clock, .rst,
    .ctrl, .aux_adc_channel(ch), .aux_adc_single_shot(one),
    .aux_adc_convert(cv), .serial_clk_slow(slow),
    .frame_sync_pins(fs), .power(pw), .status(st), .aux_adc_busy(busy));
  function logic [9:0] exp_pw(psc_ctrl_s c);
    return {~c.power_down_control[3:0], !c.clock_gate_control[2],
      !(c.clock_gate_control[5] & c.clock_gate_control[4] &
      !c.transmit_setup[3]), !(c.clock_gate_control[3] &
      c.clock_gate_control[0] & !c.receive_setup_one[3]),
      c.voice_setup_two[3], c.voice_setup_two[3] &
      (c.voice_setup_one[5] | c.voice_setup_one[4]),
      c.power_down_control[5]};
  endfunction
  task close_out;
    $display("compared %0d wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string nm, logic [9:0] seen, logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo(int k);
    if (k >= 1000) begin
      fail_count++;
      $display("wrong value wait exp done seen timeout");
      close_out();
    end
  endtask
  task put(psc_ctrl_s c);
    @(posedge clock);
    wr_val <= c;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 40; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      v = i == 0 ? '0 : i == 1 ? '1 : {lfsr[23:0], ~lfsr[31:8]};
      if (i == 2) v = 48'h20_39_00_00_10_00;
      slow <= lfsr[5];
      ch <= 3'h0;
      put(v);
      chk("power", {pw.aux_dac_on, pw.aux_logic_clk_en, pw.tx_on, pw.rx_on,
        pw.voice_on, pw.voice_amp_on, pw.bias_on}, exp_pw(v));
      chk("sps", st.samples_per_symbol, slow ? 10'h4 : 10'h8);
      chk("phase", st.rx_phase_adjust, v.receive_setup_one[6]);
      chk("adc off", pw.aux_adc_on, 1'b0);
    end
    $display("test control words done");
    // Bias is on before the receive and voice sections are enabled; the recovery wait is the five clocks between the two writes.
    put(48'h20_09_00_00_00_00);
    put(48'h20_09_00_08_30_08);
    for (n = 0; n < 1000 && st.voice_ready !== 1'b1; n++) begin
      @(posedge clock);
      #1;
      if (st.rx_data_valid !== 1'b1) nr = n + 1;
    end
    tmo(n);
    chk("voice delay", n >= 280 && n <= 292, 1'b1);
    chk("rx delay", nr >= 8 * SYM - 4 && nr <= 8 * SYM + 4, 1'b1);
    $display("test latencies done");
    ch <= 3'h2;
    for (n = 0; n < 1000 && st.aux_adc_ready !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    tmo(n);
    chk("adc warm", n <= 12 && pw.aux_adc_on === 1'b1, 1'b1);
    one <= 1'b1;
    repeat (8) @(posedge clock);
    chk("adc idle", pw.aux_adc_on, 1'b0);
    cv <= 1'b1;
    for (n = 0; n < 1000 && busy !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    tmo(n);
    cv <= 1'b0;
    for (n = 0; n < 1000 && busy !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
    tmo(n);
    repeat (4) @(posedge clock);
    chk("adc after", pw.aux_adc_on, 1'b0);
    one <= 1'b0;
    put(48'h20_0d_00_08_00_00);
    repeat (8) @(posedge clock);
    chk("adc gated", pw.aux_adc_on, 1'b0);
    $display("test aux adc done");
    slow <= 1'b1;
    fs <= 3'h4;
    put(48'h20_02_08_08_00_00);
    repeat (5 * SYM) @(posedge clock);
    chk("serial run", pw.fast_serial_port_clk_en, 1'b1);
    repeat (4 * SYM + 8) @(posedge clock);
    chk("serial stop", pw.fast_serial_port_clk_en, 1'b0);
    fs <= 3'h5;
    repeat (8) @(posedge clock);
    chk("serial wake", pw.fast_serial_port_clk_en, 1'b1);
    $display("test serial stop done");
    close_out();
  end
endmodule
